/* File: funnel_params.svh */
`ifndef FUNNEL_PARAMS_SVH
`define FUNNEL_PARAMS_SVH

`define FUNNEL_ADDR_WIDTH      4
`define FUNNEL_OFS_ENABLE      4'h0
`define FUNNEL_OFS_PRIORITY    4'h4
`define FUNNEL_OFS_STATUS      4'h8
`define FUNNEL_ENABLE_RESET    32'h00000000
`define FUNNEL_PRIORITY_RESET  32'h00000000
`define FUNNEL_PRIO_WIDTH      3
`define FUNNEL_PRIO_RESERVED_LSB 24
`define FUNNEL_MAX_PORTS       8
`define FUNNEL_FIFO_DEPTH      4

`endif

/* File: funnel_pkg.sv */
package funnel_pkg;

    typedef logic [2:0] prio_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_PUSH = 2'b01
    } arb_state_type;

endpackage : funnel_pkg

/* File: trace_fifo.sv */
`timescale 1ns/1ps
module trace_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("trace_fifo depth must be a power of two of at least two");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    rptr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign in_ready  = (count_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (count_q != '0);
    assign out_data  = mem[rptr_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wptr_q  <= '0;
            rptr_q  <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + AW'(1);
            end
            if (pop) begin
                rptr_q <= rptr_q + AW'(1);
            end
            if (push && !pop) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (pop && !push) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end

    // Occupancy never exceeds the depth.
    a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!reset_n)
        count_q <= (AW+1)'(DEPTH))
        else $error("fifo occupancy above depth");

endmodule : trace_fifo

/* File: prio_select.sv */
`timescale 1ns/1ps
`include "funnel_params.svh"
module prio_select #(
    parameter int PORTS = 8
) (
    input  wire logic [PORTS-1:0]                        request,
    input  wire logic [PORTS*`FUNNEL_PRIO_WIDTH-1:0]     prio,
    output logic                                         found,
    output logic [2:0]                                   winner
);
    // Strict less-than while scanning upward keeps the lowest index on a tie.
    always_comb begin
        funnel_pkg::prio_type best;
        found  = 1'b0;
        winner = 3'h0;
        best   = 3'h7;
        for (int i = 0; i < PORTS; i++) begin
            if (request[i] && (!found || prio[i*3 +: 3] < best)) begin
                found  = 1'b1;
                winner = 3'(i);
                best   = prio[i*3 +: 3];
            end
        end
    end
endmodule : prio_select

/* File: trace_funnel_priority_arbiter.sv */
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "funnel_params.svh"
module trace_funnel_priority_arbiter #(
    parameter int PORTS = 8,
    parameter int DATA_WIDTH = 32,
    parameter int FIFO_DEPTH = `FUNNEL_FIFO_DEPTH
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset_n,
    input  wire logic [3:0]                  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    input  wire logic [PORTS*DATA_WIDTH-1:0] src_data,
    input  wire logic [PORTS-1:0]            src_valid,
    output logic      [PORTS-1:0]            src_ready,
    output logic      [DATA_WIDTH-1:0]       sink_data,
    output logic      [2:0]                  sink_port,
    output logic                             sink_valid,
    input  wire logic                        sink_ready
);
    initial begin
        if (PORTS < 1 || PORTS > `FUNNEL_MAX_PORTS) begin
            $error("PORTS must be between 1 and 8");
        end
        if (DATA_WIDTH < 1) begin
            $error("DATA_WIDTH must be positive");
        end
    end

    localparam int PW = PORTS * `FUNNEL_PRIO_WIDTH;
    localparam int FW = DATA_WIDTH + 3;

    // ==========================================================
    // Register slave
    // ==========================================================
    funnel_pkg::reg_req_type req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [PORTS-1:0] enable_q;
    logic [PW-1:0]    prio_q;
    logic [31:0]      reg_rdata_q;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        return a == ofs;
    endfunction : hit

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            enable_q <= PORTS'(`FUNNEL_ENABLE_RESET);
        end else if (req.wr && hit(req.addr, `FUNNEL_OFS_ENABLE)) begin
            enable_q <= req.wdata[PORTS-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prio_q <= PW'(`FUNNEL_PRIORITY_RESET);
        end else if (req.wr && hit(req.addr, `FUNNEL_OFS_PRIORITY)) begin
            prio_q <= req.wdata[PW-1:0];
        end
    end

    logic             found;
    logic [2:0]       winner;
    logic             out_busy_q;
    logic             fifo_in_ready;

    // Unmapped offsets and reserved bits read as zero.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (req.rd) begin
            if (hit(req.addr, `FUNNEL_OFS_ENABLE)) begin
                reg_rdata_q <= 32'(enable_q);
            end else if (hit(req.addr, `FUNNEL_OFS_PRIORITY)) begin
                reg_rdata_q <= 32'(prio_q);
            end else if (hit(req.addr, `FUNNEL_OFS_STATUS)) begin
                reg_rdata_q <= {27'h0, fifo_in_ready, found, winner};
            end else begin
                reg_rdata_q <= 32'h00000000;
            end
        end else begin
            reg_rdata_q <= 32'h00000000;
        end
    end
    assign reg_rdata = reg_rdata_q;

    // ==========================================================
    // Arbitration
    // ==========================================================
    logic [PORTS-1:0] eligible;
    assign eligible = enable_q & src_valid;

    prio_select #(.PORTS(PORTS)) u_select (
        .request (eligible),
        .prio    (prio_q),
        .found   (found),
        .winner  (winner)
    );

    // Grant is one cycle wide; the source pops one beat on it. Priority is
    // re-evaluated every beat, so a changed field applies from the cycle after
    // the write, whether or not software disabled the port first.
    logic [FW-1:0] fifo_in;
    logic          take;
    assign take = found && fifo_in_ready;
    assign fifo_in = {winner, src_data[winner*DATA_WIDTH +: DATA_WIDTH]};

    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_ready
            assign src_ready[g] = take && (winner == 3'(g));
        end
    endgenerate

    logic [FW-1:0] fifo_out;
    logic          fifo_out_valid;
    logic          fifo_pop;
    assign fifo_pop = fifo_out_valid && (!out_busy_q || sink_ready);

    trace_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_data   (fifo_in),
        .in_valid  (found),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // ==========================================================
    // Registered output stage
    // ==========================================================
    logic [DATA_WIDTH-1:0] sink_data_q;
    logic [2:0]            sink_port_q;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            out_busy_q  <= 1'b0;
            sink_data_q <= '0;
            sink_port_q <= 3'h0;
        end else if (fifo_pop) begin
            out_busy_q  <= 1'b1;
            sink_data_q <= fifo_out[DATA_WIDTH-1:0];
            sink_port_q <= fifo_out[FW-1 -: 3];
        end else if (sink_ready) begin
            out_busy_q <= 1'b0;
        end
    end
    assign sink_valid = out_busy_q;
    assign sink_data  = sink_data_q;
    assign sink_port  = sink_port_q;

    // ==========================================================
    // Check helpers
    // ==========================================================
    // A pairwise rescan, written apart from the selector, so that a slip in
    // the selector's running minimum cannot also hide inside its own check.
    logic [PORTS-1:0] outranks;
    logic [PORTS-1:0] ties_lower;
    logic [2:0]       winner_prio;
    assign winner_prio = prio_q[winner*3 +: 3];

    genvar h;
    generate
        for (h = 0; h < PORTS; h++) begin : g_rank
            assign outranks[h]   = eligible[h] && (prio_q[h*3 +: 3] < winner_prio);
            // An equal field only beats the winner from a lower port number.
            assign ties_lower[h] = eligible[h] && (prio_q[h*3 +: 3] == winner_prio)
                                   && (3'(h) < winner);

            a_port_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
                src_ready[h] |-> (enable_q[h] && src_valid[h]))
                else $error("port granted while disabled or idle");
        end
    endgenerate

    // Beats granted and not yet taken by the sink. Buffer and output register
    // together hold at most FIFO_DEPTH + 1, so a larger count means a beat was
    // duplicated or granted without room.
    localparam int IW = $clog2(FIFO_DEPTH + 2) + 1;
    logic [IW-1:0] inflight_q;
    logic          sink_take;
    assign sink_take = sink_valid && sink_ready;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            inflight_q <= '0;
        end else if (take && !sink_take) begin
            inflight_q <= inflight_q + IW'(1);
        end else if (sink_take && !take) begin
            inflight_q <= inflight_q - IW'(1);
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    a_no_disabled_grant: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (src_ready & ~enable_q) == '0)
        else $error("disabled port granted");

    a_grant_lowest_prio: assert property (@(posedge clk_sys) disable iff (!reset_n)
        take |-> (src_valid[winner] && enable_q[winner] && (outranks == '0)))
        else $error("granted port was not the best eligible one");

    a_tie_lowest_port: assert property (@(posedge clk_sys) disable iff (!reset_n)
        take |-> (ties_lower == '0))
        else $error("lower port with equal priority lost the tie");

    a_enable_reset_zero: assert property (@(posedge clk_sys)
        $rose(reset_n) |-> (enable_q == '0))
        else $error("enables not clear after reset");

    a_enable_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.wr && req.addr == `FUNNEL_OFS_ENABLE) |=> (enable_q == $past(req.wdata[PORTS-1:0])))
        else $error("enable write not stored");

    a_prio_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.wr && req.addr == `FUNNEL_OFS_PRIORITY) |=> (prio_q == $past(req.wdata[PW-1:0])))
        else $error("priority write not stored");

    a_read_priority: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.rd && req.addr == `FUNNEL_OFS_PRIORITY && !req.wr)
        ##1 1'b1 |-> (reg_rdata[31:24] == 8'h00))
        else $error("reserved priority bits not zero");

    a_forward_winner: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (found && fifo_in_ready && !fifo_out_valid && !out_busy_q)
        |=> ##1 (sink_valid && sink_port == $past(winner, 2)))
        else $error("winner not forwarded");

    a_single_grant: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $onehot0(src_ready))
        else $error("more than one port granted");

    // Out of reset nothing may be granted, shown or read back.
    a_reset_quiet: assert property (@(posedge clk_sys)
        $rose(reset_n) |-> (!sink_valid && (src_ready == '0) && (reg_rdata == 32'h00000000)))
        else $error("outputs active right after reset");

    a_prio_reset_zero: assert property (@(posedge clk_sys)
        $rose(reset_n) |-> (prio_q == '0))
        else $error("priorities not clear after reset");

    a_read_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.rd && req.addr == `FUNNEL_OFS_ENABLE) |=> (reg_rdata == 32'($past(enable_q))))
        else $error("enable read back wrong");

    a_read_prio: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.rd && req.addr == `FUNNEL_OFS_PRIORITY) |=> (reg_rdata == 32'($past(prio_q))))
        else $error("priority read back wrong");

    // Idle cycles return zero, so a stale word can never pass as a fresh read.
    a_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !req.rd |=> (reg_rdata == 32'h00000000))
        else $error("read data not zero outside a read");

    a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (req.rd && req.addr != `FUNNEL_OFS_ENABLE && req.addr != `FUNNEL_OFS_PRIORITY
         && req.addr != `FUNNEL_OFS_STATUS) |=> (reg_rdata == 32'h00000000))
        else $error("unmapped offset read not zero");

    a_stall_when_full: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !fifo_in_ready |-> (src_ready == '0))
        else $error("grant made while buffer full");

    a_grant_when_found: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (found && fifo_in_ready) |-> (src_ready != '0))
        else $error("eligible port left waiting with room free");

    // The sink may stall for any time; the beat it sees must not move under it.
    a_sink_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (sink_valid && !sink_ready) |=> (sink_valid && $stable(sink_data) && $stable(sink_port)))
        else $error("output beat changed while stalled");

    a_beats_conserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
        inflight_q <= IW'(FIFO_DEPTH + 1))
        else $error("more beats in flight than storage");

    a_idle_empty: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (inflight_q == '0) |-> (!sink_valid && !fifo_out_valid))
        else $error("beat shown with none in flight");

endmodule : trace_funnel_priority_arbiter

/* File: trace_source_model.sv */
`timescale 1ns/1ps
module trace_source_model #(
    parameter int PORTS = 8,
    parameter int W     = 32
) (
    input  wire logic           clk_sys,
    input  wire logic           reset_n,
    input  wire logic [PORTS-1:0] offer,
    input  wire logic [PORTS-1:0] src_ready,
    output logic [PORTS*W-1:0]  src_data,
    output logic [PORTS-1:0]    src_valid
);
    logic [23:0] cnt_q [PORTS];
    logic [PORTS-1:0] valid_q;

    // ==========================================
    // Beat sequencing
    // valid data offer.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            valid_q <= '0;
            for (int n = 0; n < PORTS; n++) cnt_q[n] <= 24'h000000;
        end else begin
            valid_q <= offer;
            for (int n = 0; n < PORTS; n++) begin
                if (src_ready[n] && valid_q[n]) cnt_q[n] <= cnt_q[n] + 24'h000001;
            end
        end
    end

    // Idle lanes show the inverted beat so a stale value can never pass as fresh.
    always_comb begin
        for (int n = 0; n < PORTS; n++) begin
            src_data[n*W +: W] = valid_q[n] ? {8'(n), cnt_q[n]} : ~{8'(n), cnt_q[n]};
        end
    end
    assign src_valid = valid_q;
endmodule : trace_source_model

/* File: trace_funnel_priority_arbiter_test.sv */
`timescale 1ns/1ps
module trace_funnel_priority_arbiter_test;
    logic        clk_sys, reset_n, reg_wr, reg_rd, sink_valid, sink_ready;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, sink_data;
    logic [255:0] src_data;
    logic [7:0]  src_valid, src_ready, offer;
    logic [2:0]  sink_port;
    int          fails, checks;

    trace_funnel_priority_arbiter #(.PORTS(8), .DATA_WIDTH(32), .FIFO_DEPTH(4)) dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_data(src_data), .src_valid(src_valid),
        .src_ready(src_ready), .sink_data(sink_data), .sink_port(sink_port),
        .sink_valid(sink_valid), .sink_ready(sink_ready));
    trace_source_model #(.PORTS(8), .W(32)) src_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .offer(offer),
        .src_ready(src_ready), .src_data(src_data), .src_valid(src_valid));

    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask : reg_read

    task automatic wrap_up();
        $display("fails=%0d checks=%0d", fails, checks);
        if (fails == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // ==========================================
    // Scenarios
    task automatic regs_test();
        logic [31:0] d;
        reg_read(4'h0, d); check(d, 32'h00000000);
        reg_read(4'h4, d); check(d, 32'h00000000);
        reg_write(4'h4, 32'hFFFFFFFF);
        reg_read(4'h4, d); check(d, 32'h00FFFFFF);
        reg_write(4'h4, 32'h00000038);
        reg_read(4'h4, d); check(d, 32'h00000038);
        reg_write(4'h0, 32'hFFFFFFFF);
        reg_read(4'h0, d); check(d, 32'h000000FF);
        reg_write(4'hC, 32'hFFFFFFFF);
        reg_read(4'hC, d); check(d, 32'h00000000);
    endtask : regs_test

    // Holds the sink back so the buffer fills, then takes the first beat.
    task automatic arb_case(input logic [31:0] p, input logic [7:0] en,
                            input logic [7:0] mask, input logic [2:0] exp, input logic any);
        int n;
        int i;
        logic [31:0] d;
        reg_write(4'h0, 32'h00000000);
        reg_write(4'h4, p);
        reg_write(4'h0, {24'h000000, en});
        @(posedge clk_sys);
        offer <= mask;
        n = 0;
        repeat (14) begin
            @(negedge clk_sys);
            if (src_ready !== 8'h00) n++;
        end
        check(src_ready, 8'h00);
        check(n, any ? 5 : 0);
        if (any) begin
            // Buffer full and sink stalled: status shows the winner, found, no room.
            reg_read(4'h8, d);
            check(d, {27'h0000000, 2'b01, exp});
            @(posedge clk_sys);
            sink_ready <= 1'b1;
            i = 0;
            do begin
                @(negedge clk_sys);
                i++;
            end while (sink_valid !== 1'b1 && i < 40);
            check(sink_valid, 1'b1);
            check(sink_port, exp);
            check(sink_data[31:24], 8'(exp));
        end else begin
            check(sink_valid, 1'b0);
            reg_read(4'h8, d);
            check(d, 32'h00000010);
        end
        @(posedge clk_sys);
        offer      <= 8'h00;
        sink_ready <= 1'b1;
        repeat (12) @(posedge clk_sys);
        sink_ready <= 1'b0;
    endtask : arb_case

    // ==========================================
    // Main sequence
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial begin
        #100000;
        fails++;
        wrap_up();
    end

    initial begin
        fails = 0;
        checks = 0;
        reset_n = 1'b0;
        {reg_wr, reg_rd, sink_ready} = 3'b000;
        reg_addr = 4'h0;
        reg_wdata = 32'h00000000;
        offer = 8'h00;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        regs_test();
        arb_case(32'h00000000, 8'h00, 8'hFF, 3'h0, 1'b0);
        arb_case(32'h00053977, 8'hFF, 8'hFF, 3'h7, 1'b1);
        arb_case(32'h00053977, 8'h7F, 8'hFF, 3'h6, 1'b1);
        arb_case(32'h00053977, 8'hFF, 8'h01, 3'h0, 1'b1);
        arb_case(32'h006DB6DB, 8'hFF, 8'hFC, 3'h2, 1'b1);
        arb_case(32'h00000000, 8'h20, 8'hFF, 3'h5, 1'b1);
        wrap_up();
    end
endmodule : trace_funnel_priority_arbiter_test
